// ===== verilog/tdchm_map.svh
// What this block does
// - Mode two result is selected stop time minus start time.
// - Mode two accepts and times at most three stop hits.
// - Mode two second operand picks first, second or third hit of stop A.
// - Mode two first operand stays start; stop-to-stop is not offered.
// - Mode one result is first operand time minus second operand time.
// - Mode one operands may pick start or any hit on either stop channel.
// - Analog off uses digital stop pins; analog on uses the receiver output.
// - Charge time selects 90, 120, 150 or 300 us; 300 after reset.
// - Mode bit set selects mode two, cleared selects mode one.
// - Mode two auto sum computes all three hit times and their sum.
// - Mode two timeout window of 64 to 1024 us flags missing hits.
// - Each stop channel has its own expected hit count for completion.
// - Start triggers on falling edge when selected, else rising edge.
// - Stops trigger rising by default, falling or both when selected.
// - Signal an interrupt when the expected hits have arrived.
// - Signal an interrupt when the measuring counter overflows.
`ifndef TDCHM_MAP_SVH
`define TDCHM_MAP_SVH

`define TDCHM_CLK_MHZ 25
`define TDCHM_TS_W 16
`define TDCHM_TS_MAX 16'hFFFF
`define TDCHM_HIT_MAX 4
`define TDCHM_HIT_MAX_MM2 3

`define TDCHM_CHG_90_US 90
`define TDCHM_CHG_120_US 120
`define TDCHM_CHG_150_US 150
`define TDCHM_CHG_300_US 300
`define TDCHM_CHG_SEL_90 2'h0
`define TDCHM_CHG_SEL_120 2'h1
`define TDCHM_CHG_SEL_150 2'h2
`define TDCHM_CHG_SEL_300 2'h3
`define TDCHM_CHG_SEL_RST 2'h3

`define TDCHM_TMO_64_US 64
`define TDCHM_TMO_256_US 256
`define TDCHM_TMO_1024_US 1024
`define TDCHM_TMO_SEL_64 2'h0
`define TDCHM_TMO_SEL_256 2'h1
`define TDCHM_TMO_SEL_RST 2'h0

`define TDCHM_OP_START 4'h0
`define TDCHM_OP_A_BASE 4'h1
`define TDCHM_OP_B_BASE 4'h9
`define TDCHM_OP_SEL_RST 4'h0
`define TDCHM_EXP_RST 3'h1

`endif

// ===== verilog/tdchm_pkg.sv
package tdchm_pkg;

  typedef enum logic [2:0] {
    TDCHM_IDLE,
    TDCHM_CHARGE,
    TDCHM_WAIT_START,
    TDCHM_COLLECT,
    TDCHM_CALC
  } tdchm_state_t;

  typedef enum logic {
    TDCHM_MODE_ONE,
    TDCHM_MODE_TWO
  } tdchm_mode_t;

endpackage : tdchm_pkg

// ===== verilog/tdchm_edge_det.sv
`timescale 1ns/1ps
module tdchm_edge_det (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  input wire logic falling_sel,
  input wire logic both_sel,
  output logic edge_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Both-edges is tested first so it overrides the falling choice.
  always_comb begin
    if (both_sel) begin
      edge_pulse = sync_reg ^ prev_reg;
    end else if (falling_sel) begin
      edge_pulse = prev_reg & ~sync_reg;
    end else begin
      edge_pulse = sync_reg & ~prev_reg;
    end
  end
endmodule : tdchm_edge_det

// ===== verilog/tdchm_top.sv
`timescale 1ns/1ps
`include "tdchm_map.svh"
module tdchm_top #(
  parameter int CHG_300_CYC = `TDCHM_CHG_300_US * `TDCHM_CLK_MHZ,
  parameter int TMO_256_CYC = `TDCHM_TMO_256_US * `TDCHM_CLK_MHZ,
  parameter int TMO_1024_CYC = `TDCHM_TMO_1024_US * `TDCHM_CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic measure_start,
  input wire logic mode_two,
  input wire logic analog_enable,
  input wire logic [1:0] cap_charge_time,
  input wire logic [1:0] timeout_window_select,
  input wire logic auto_sum_three_hits,
  input wire logic [3:0] first_operand_select,
  input wire logic [3:0] second_operand_select,
  input wire logic [2:0] expected_hits_a,
  input wire logic [2:0] expected_hits_b,
  input wire logic start_falling,
  input wire logic stop_a_falling,
  input wire logic stop_a_both,
  input wire logic stop_b_falling,
  input wire logic stop_b_both,
  input wire logic start_pin,
  input wire logic stop_input_a,
  input wire logic stop_input_b,
  input wire logic afe_stop_a,
  input wire logic afe_stop_b,
  output logic charge_capacitor,
  output logic measuring,
  output logic result_valid,
  output logic [15:0] result_one,
  output logic [15:0] result_two,
  output logic [15:0] result_three,
  output logic [17:0] result_sum,
  output logic timeout_flag,
  output logic hits_done_irq,
  output logic timeout_irq
);
  localparam int CHG_90_CYC = `TDCHM_CHG_90_US * `TDCHM_CLK_MHZ;
  localparam int CHG_120_CYC = `TDCHM_CHG_120_US * `TDCHM_CLK_MHZ;
  localparam int CHG_150_CYC = `TDCHM_CHG_150_US * `TDCHM_CLK_MHZ;
  localparam int TMO_64_CYC = `TDCHM_TMO_64_US * `TDCHM_CLK_MHZ;

  tdchm_pkg::tdchm_state_t state_reg;
  tdchm_pkg::tdchm_mode_t mode_reg;
  logic analog_reg;
  logic [1:0] chg_sel_reg;
  logic [1:0] tmo_sel_reg;
  logic auto_reg;
  logic [3:0] op1_reg;
  logic [3:0] op2_reg;
  logic [2:0] exp_a_reg;
  logic [2:0] exp_b_reg;
  logic [12:0] chg_cnt_reg;
  logic [15:0] elapsed_reg;
  logic [2:0] hit_a_reg;
  logic [2:0] hit_b_reg;
  logic [15:0] stamp_reg [2][`TDCHM_HIT_MAX];
  logic start_edge;
  logic stop_a_edge;
  logic stop_b_edge;
  logic stop_a_src;
  logic stop_b_src;
  logic [12:0] chg_target;
  logic [15:0] tmo_target;
  logic [2:0] cap_a;
  logic hits_complete;
  logic tmo_hit;

  // Source choice is static during a measurement, so muxing ahead of the
  // synchroniser costs nothing and saves two synchronisers.
  assign stop_a_src = analog_reg ? afe_stop_a : stop_input_a;
  assign stop_b_src = analog_reg ? afe_stop_b : stop_input_b;

  tdchm_edge_det u_start (
    .clk(clk),
    .reset(reset),
    .pin(start_pin),
    .falling_sel(start_falling),
    .both_sel(1'b0),
    .edge_pulse(start_edge)
  );
  tdchm_edge_det u_stop_a (
    .clk(clk),
    .reset(reset),
    .pin(stop_a_src),
    .falling_sel(stop_a_falling),
    .both_sel(stop_a_both),
    .edge_pulse(stop_a_edge)
  );
  tdchm_edge_det u_stop_b (
    .clk(clk),
    .reset(reset),
    .pin(stop_b_src),
    .falling_sel(stop_b_falling),
    .both_sel(stop_b_both),
    .edge_pulse(stop_b_edge)
  );

  function automatic logic [15:0] op_time(input logic [3:0] sel);
    logic [3:0] ia;
    logic [3:0] ib;
    ia = sel - `TDCHM_OP_A_BASE;
    ib = sel - `TDCHM_OP_B_BASE;
    if (sel >= `TDCHM_OP_A_BASE && ia < 4'h4) begin
      op_time = stamp_reg[0][ia[1:0]];
    end else if (sel >= `TDCHM_OP_B_BASE && ib < 4'h4) begin
      op_time = stamp_reg[1][ib[1:0]];
    end else begin
      op_time = 16'h0000;
    end
  endfunction : op_time

  always_comb begin
    unique case (chg_sel_reg)
      `TDCHM_CHG_SEL_90: chg_target = 13'(CHG_90_CYC);
      `TDCHM_CHG_SEL_120: chg_target = 13'(CHG_120_CYC);
      `TDCHM_CHG_SEL_150: chg_target = 13'(CHG_150_CYC);
      `TDCHM_CHG_SEL_300: chg_target = 13'(CHG_300_CYC);
    endcase
  end

  always_comb begin
    unique case (tmo_sel_reg)
      `TDCHM_TMO_SEL_64: tmo_target = 16'(TMO_64_CYC);
      `TDCHM_TMO_SEL_256: tmo_target = 16'(TMO_256_CYC);
      default: tmo_target = 16'(TMO_1024_CYC);
    endcase
  end

  // Mode two has a three-hit ceiling and ignores stop B.
  assign cap_a = (mode_reg == tdchm_pkg::TDCHM_MODE_TWO) ?
                 3'(`TDCHM_HIT_MAX_MM2) : 3'(`TDCHM_HIT_MAX);
  assign hits_complete = (hit_a_reg >= exp_a_reg) &&
                         (hit_b_reg >= exp_b_reg);
  // Mode one times out on counter wrap, mode two on the window.
  assign tmo_hit = (mode_reg == tdchm_pkg::TDCHM_MODE_TWO) ?
                   (elapsed_reg >= tmo_target) :
                   (elapsed_reg == `TDCHM_TS_MAX);

  // Configuration is captured at measurement start so a host change
  // mid-measurement cannot corrupt operand decoding.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= tdchm_pkg::TDCHM_MODE_ONE;
      analog_reg <= 1'b0;
      chg_sel_reg <= `TDCHM_CHG_SEL_RST;
      tmo_sel_reg <= `TDCHM_TMO_SEL_RST;
      auto_reg <= 1'b0;
      op1_reg <= `TDCHM_OP_SEL_RST;
      op2_reg <= `TDCHM_OP_SEL_RST;
      exp_a_reg <= `TDCHM_EXP_RST;
      exp_b_reg <= 3'h0;
    end else if (state_reg == tdchm_pkg::TDCHM_IDLE && measure_start) begin
      mode_reg <= mode_two ? tdchm_pkg::TDCHM_MODE_TWO :
                             tdchm_pkg::TDCHM_MODE_ONE;
      analog_reg <= analog_enable;
      chg_sel_reg <= cap_charge_time;
      tmo_sel_reg <= timeout_window_select;
      auto_reg <= auto_sum_three_hits & mode_two;
      if (mode_two) begin
        op1_reg <= `TDCHM_OP_START;
        op2_reg <= (second_operand_select >= `TDCHM_OP_A_BASE &&
                    second_operand_select <= 4'h3) ?
                   second_operand_select : `TDCHM_OP_A_BASE;
        exp_a_reg <= (expected_hits_a > 3'(`TDCHM_HIT_MAX_MM2)) ?
                     3'(`TDCHM_HIT_MAX_MM2) : expected_hits_a;
        exp_b_reg <= 3'h0;
      end else begin
        op1_reg <= first_operand_select;
        op2_reg <= second_operand_select;
        exp_a_reg <= expected_hits_a;
        exp_b_reg <= expected_hits_b;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= tdchm_pkg::TDCHM_IDLE;
      chg_cnt_reg <= 13'h0000;
      charge_capacitor <= 1'b0;
      measuring <= 1'b0;
    end else begin
      unique case (state_reg)
        tdchm_pkg::TDCHM_IDLE: begin
          if (measure_start) begin
            chg_cnt_reg <= 13'h0000;
            charge_capacitor <= analog_enable;
            measuring <= 1'b1;
            state_reg <= analog_enable ? tdchm_pkg::TDCHM_CHARGE :
                                         tdchm_pkg::TDCHM_WAIT_START;
          end
        end
        tdchm_pkg::TDCHM_CHARGE: begin
          chg_cnt_reg <= chg_cnt_reg + 13'h0001;
          if (chg_cnt_reg + 13'h0001 >= chg_target) begin
            charge_capacitor <= 1'b0;
            state_reg <= tdchm_pkg::TDCHM_WAIT_START;
          end
        end
        tdchm_pkg::TDCHM_WAIT_START: begin
          if (start_edge) begin
            state_reg <= tdchm_pkg::TDCHM_COLLECT;
          end
        end
        tdchm_pkg::TDCHM_COLLECT: begin
          if (hits_complete || tmo_hit) begin
            state_reg <= tdchm_pkg::TDCHM_CALC;
          end
        end
        tdchm_pkg::TDCHM_CALC: begin
          measuring <= 1'b0;
          state_reg <= tdchm_pkg::TDCHM_IDLE;
        end
      endcase
    end
  end

  // Stamps are cycles since the start edge, so start time is zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      elapsed_reg <= 16'h0000;
      hit_a_reg <= 3'h0;
      hit_b_reg <= 3'h0;
      for (int c = 0; c < 2; c++) begin
        for (int h = 0; h < `TDCHM_HIT_MAX; h++) begin
          stamp_reg[c][h] <= 16'h0000;
        end
      end
    end else if (state_reg == tdchm_pkg::TDCHM_WAIT_START) begin
      elapsed_reg <= 16'h0000;
      hit_a_reg <= 3'h0;
      hit_b_reg <= 3'h0;
    end else if (state_reg == tdchm_pkg::TDCHM_COLLECT) begin
      elapsed_reg <= elapsed_reg + 16'h0001;
      if (stop_a_edge && hit_a_reg < cap_a) begin
        stamp_reg[0][hit_a_reg[1:0]] <= elapsed_reg;
        hit_a_reg <= hit_a_reg + 3'h1;
      end
      if (stop_b_edge && mode_reg == tdchm_pkg::TDCHM_MODE_ONE &&
          hit_b_reg < 3'(`TDCHM_HIT_MAX)) begin
        stamp_reg[1][hit_b_reg[1:0]] <= elapsed_reg;
        hit_b_reg <= hit_b_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hits_done_irq <= 1'b0;
      timeout_irq <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      hits_done_irq <= state_reg == tdchm_pkg::TDCHM_COLLECT &&
                       hits_complete;
      timeout_irq <= state_reg == tdchm_pkg::TDCHM_COLLECT &&
                     !hits_complete && tmo_hit;
      if (state_reg == tdchm_pkg::TDCHM_COLLECT && !hits_complete &&
          tmo_hit) begin
        timeout_flag <= 1'b1;
      end else if (state_reg == tdchm_pkg::TDCHM_IDLE && measure_start) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_valid <= 1'b0;
      result_one <= 16'h0000;
      result_two <= 16'h0000;
      result_three <= 16'h0000;
      result_sum <= 18'h00000;
    end else if (state_reg == tdchm_pkg::TDCHM_CALC) begin
      result_valid <= !timeout_flag;
      if (auto_reg) begin
        result_one <= stamp_reg[0][0];
        result_two <= stamp_reg[0][1];
        result_three <= stamp_reg[0][2];
        result_sum <= 18'(stamp_reg[0][0]) + 18'(stamp_reg[0][1]) +
                      18'(stamp_reg[0][2]);
      end else if (mode_reg == tdchm_pkg::TDCHM_MODE_TWO) begin
        result_one <= op_time(op2_reg) - op_time(op1_reg);
      end else begin
        result_one <= op_time(op1_reg) - op_time(op2_reg);
      end
    end else if (state_reg == tdchm_pkg::TDCHM_IDLE && measure_start) begin
      result_valid <= 1'b0;
    end
  end

  logic [12:0] chg_len_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chg_len_reg <= 13'h0000;
    end else if (charge_capacitor) begin
      chg_len_reg <= chg_len_reg + 13'h0001;
    end else begin
      chg_len_reg <= 13'h0000;
    end
  end

  property p_mm2_stop_minus_start;
    @(posedge clk) disable iff (reset)
    $rose(result_valid) && mode_reg == tdchm_pkg::TDCHM_MODE_TWO &&
    !auto_reg |-> result_one == op_time(op2_reg);
  endproperty
  a_mm2_stop_minus_start: assert property (p_mm2_stop_minus_start)
    else $error("mode two result is not stop minus start");

  // Counts left by a mode one run are cleared only on entering the wait.
  property p_mm2_hit_cap;
    @(posedge clk) disable iff (reset)
    mode_reg == tdchm_pkg::TDCHM_MODE_TWO &&
    state_reg inside {tdchm_pkg::TDCHM_COLLECT, tdchm_pkg::TDCHM_CALC} |->
    hit_a_reg <= 3'h3 && hit_b_reg == 3'h0;
  endproperty
  a_mm2_hit_cap: assert property (p_mm2_hit_cap)
    else $error("mode two took more than three stop hits");

  property p_mm2_op1_start;
    @(posedge clk) disable iff (reset)
    state_reg == tdchm_pkg::TDCHM_COLLECT &&
    mode_reg == tdchm_pkg::TDCHM_MODE_TWO |->
    op1_reg == `TDCHM_OP_START && op2_reg inside {4'h1, 4'h2, 4'h3};
  endproperty
  a_mm2_op1_start: assert property (p_mm2_op1_start)
    else $error("mode two operand selection out of range");

  property p_mm1_diff;
    @(posedge clk) disable iff (reset)
    $rose(result_valid) && mode_reg == tdchm_pkg::TDCHM_MODE_ONE |->
    result_one == 16'(op_time(op1_reg) - op_time(op2_reg));
  endproperty
  a_mm1_diff: assert property (p_mm1_diff)
    else $error("mode one result is not first minus second");

  property p_charge_len;
    @(posedge clk) disable iff (reset)
    $fell(charge_capacitor) && state_reg == tdchm_pkg::TDCHM_WAIT_START
    |-> $past(chg_len_reg) + 13'h0001 == chg_target;
  endproperty
  a_charge_len: assert property (p_charge_len)
    else $error("charge time does not match selection");

  property p_charge_analog;
    @(posedge clk) disable iff (reset)
    charge_capacitor |-> analog_reg && measuring;
  endproperty
  a_charge_analog: assert property (p_charge_analog)
    else $error("capacitor charged with analog section off");

  property p_auto_sum;
    @(posedge clk) disable iff (reset)
    $rose(result_valid) && auto_reg |-> result_sum ==
    18'(result_one) + 18'(result_two) + 18'(result_three);
  endproperty
  a_auto_sum: assert property (p_auto_sum)
    else $error("auto sum differs from the three hit times");

  property p_done_irq;
    @(posedge clk) disable iff (reset)
    hits_done_irq |-> $past(hit_a_reg) >= $past(exp_a_reg) &&
    $past(hit_b_reg) >= $past(exp_b_reg) ##1 !hits_done_irq;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("hit interrupt without expected hits");

  property p_tmo_irq;
    @(posedge clk) disable iff (reset)
    timeout_irq |-> ($past(mode_reg) == tdchm_pkg::TDCHM_MODE_ONE ?
    $past(elapsed_reg) == `TDCHM_TS_MAX :
    $past(elapsed_reg) >= $past(tmo_target)) ##1 timeout_flag;
  endproperty
  a_tmo_irq: assert property (p_tmo_irq)
    else $error("timeout interrupt before the limit");
endmodule : tdchm_top

// ===== bench/tdchm_pulse_src.sv
`timescale 1ns/1ps
module tdchm_pulse_src (
  input wire logic clk,
  output logic start_pin,
  output logic stop_input_a,
  output logic stop_input_b,
  output logic afe_stop_a,
  output logic afe_stop_b
);
  logic [4:0] lvl_reg = 5'h00;

  assign {afe_stop_b, afe_stop_a, stop_input_b, stop_input_a,
    start_pin} = lvl_reg;

  // Each event is cycle*8+line and flips that line, so a pulse is two
  // events. A source holds its level between events, as a driver would.
  task automatic play(input int ev[$]);
    int c;
    c = 0;
    ev.sort();
    while (ev.size() > 0) begin
      @(posedge clk);
      #5;
      while (ev.size() > 0 && (ev[0] >> 3) == c) begin
        lvl_reg[ev[0] & 7] = ~lvl_reg[ev[0] & 7];
        void'(ev.pop_front());
      end
      c++;
    end
  endtask : play
endmodule : tdchm_pulse_src

// ===== bench/tdc_hit_measurement_control_tb_top.sv
`timescale 1ns/1ps
module tdc_hit_measurement_control_tb_top;
  typedef struct {
    logic tmo;
    logic all;
    logic [17:0] e1;
    logic [17:0] e2;
    logic [17:0] e3;
    int tol;
    int chg;
  } tdchm_tb_note_t;

  logic clk, reset, measure_start, mode_two, analog_enable;
  logic [1:0] cap_charge_time, timeout_window_select;
  logic auto_sum_three_hits;
  logic [3:0] first_operand_select, second_operand_select;
  logic [2:0] expected_hits_a, expected_hits_b;
  logic start_falling, stop_a_falling, stop_a_both;
  logic stop_b_falling, stop_b_both;
  logic start_pin, stop_input_a, stop_input_b, afe_stop_a, afe_stop_b;
  logic charge_capacitor, measuring, result_valid;
  logic [15:0] result_one, result_two, result_three;
  logic [17:0] result_sum;
  logic timeout_flag, hits_done_irq, timeout_irq;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int t_start = 0;
  int chg_run = 0;
  int chg_len = 0;
  int tn = 0;
  int seed = 3598;
  logic rv_q = 1'b0;
  logic hd_seen = 1'b0;
  tdchm_tb_note_t notes[$];
  tdchm_tb_note_t mon_n;
  int ev[$];
  int g1, g2, w1;
  int chg_cyc[4] = '{2250, 3000, 3750, 7500};
  int tmo_cyc[3] = '{1600, 6400, 3200};

  // The longest window is shortened to 3200 cycles so the timeout sweep stays short.
  tdchm_top #(.TMO_1024_CYC(3200)) u_tdchm_top (
    .clk(clk), .reset(reset), .measure_start(measure_start),
    .mode_two(mode_two), .analog_enable(analog_enable),
    .cap_charge_time(cap_charge_time),
    .timeout_window_select(timeout_window_select),
    .auto_sum_three_hits(auto_sum_three_hits),
    .first_operand_select(first_operand_select),
    .second_operand_select(second_operand_select),
    .expected_hits_a(expected_hits_a), .expected_hits_b(expected_hits_b),
    .start_falling(start_falling), .stop_a_falling(stop_a_falling),
    .stop_a_both(stop_a_both), .stop_b_falling(stop_b_falling),
    .stop_b_both(stop_b_both), .start_pin(start_pin),
    .stop_input_a(stop_input_a), .stop_input_b(stop_input_b),
    .afe_stop_a(afe_stop_a), .afe_stop_b(afe_stop_b),
    .charge_capacitor(charge_capacitor), .measuring(measuring),
    .result_valid(result_valid), .result_one(result_one),
    .result_two(result_two), .result_three(result_three),
    .result_sum(result_sum), .timeout_flag(timeout_flag),
    .hits_done_irq(hits_done_irq), .timeout_irq(timeout_irq)
  );

  tdchm_pulse_src u_tdchm_pulse_src (
    .clk(clk), .start_pin(start_pin), .stop_input_a(stop_input_a),
    .stop_input_b(stop_input_b), .afe_stop_a(afe_stop_a),
    .afe_stop_b(afe_stop_b)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("TB: %0d checks, %0d mismatches", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // Pin timing through the synchronisers shifts stamps relative to start,
  // so those values get a window of tol cycles below the ideal figure.
  task automatic chk(input logic [17:0] got, input logic [17:0] exp,
    input int tol);
    logic [17:0] lo;
    lo = exp - tol;
    check_count++;
    if ((got >= lo) !== 1'b1 || (got <= exp) !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic tdchm_tb_note_t mk(input logic tmo, input logic all,
    input int e1, input int e2, input int e3, input int tol,
    input int chg);
    tdchm_tb_note_t n;
    n = '{tmo, all, e1[17:0], e2[17:0], e3[17:0], tol, chg};
    return n;
  endfunction : mk

  task automatic pulse(input int t0, input int w, input int ch);
    ev.push_back(t0 * 8 + ch);
    ev.push_back((t0 + w) * 8 + ch);
  endtask : pulse

  task automatic run(input tdchm_tb_note_t n);
    int k;
    notes.push_back(n);
    measure_start = 1'b1;
    @(posedge clk);
    #5;
    measure_start = 1'b0;
    k = 0;
    while (charge_capacitor === 1'b1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    // Let the two-flop synchronisers settle on the idle pin levels.
    repeat (4) @(posedge clk);
    t_start = cyc + 1;
    u_tdchm_pulse_src.play(ev);
    ev.delete();
    k = 0;
    while (measuring === 1'b1 && k < 70000) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    #5;
    if (k == 70000 || notes.size() != 0) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, k, 0);
      finish_test();
    end
    $display("TB: test %0d done", tn);
    tn++;
  endtask : run

  always @(posedge clk) begin
    cyc <= cyc + 1;
    rv_q <= result_valid;
    if (hits_done_irq === 1'b1) hd_seen = 1'b1;
    if (charge_capacitor === 1'b1) begin
      chg_run <= chg_run + 1;
    end else if (chg_run != 0) begin
      chg_len <= chg_run;
      chg_run <= 0;
    end
    if ((result_valid === 1'b1 && rv_q !== 1'b1) ||
        timeout_irq === 1'b1) begin
      if (notes.size() == 0) begin
        error_cnt++;
        $display("unexpected at %0t got %h exp %h", $time, 1, 0);
      end else begin
        mon_n = notes.pop_front();
        chk(timeout_flag, mon_n.tmo, 0);
        chk(hd_seen, !mon_n.tmo, 0);
        hd_seen = 1'b0;
        if (mon_n.chg >= 0) chk(chg_len, mon_n.chg, 0);
        if (mon_n.tmo === 1'b1) begin
          chk(cyc - t_start, mon_n.e1, mon_n.tol);
        end else begin
          chk(result_one, mon_n.e1, mon_n.tol);
          if (mon_n.all === 1'b1) begin
            chk(result_two, mon_n.e2, mon_n.tol);
            chk(result_three, mon_n.e3, mon_n.tol);
            chk(result_three - result_one, mon_n.e3 - mon_n.e1, 0);
            chk(result_sum, mon_n.e1 + mon_n.e2 + mon_n.e3,
              3 * mon_n.tol);
          end
        end
      end
    end
  end

  initial begin
    reset = 1'b1;
    measure_start = 1'b0;
    mode_two = 1'b0;
    analog_enable = 1'b0;
    cap_charge_time = 2'h3;
    timeout_window_select = 2'h0;
    auto_sum_three_hits = 1'b0;
    first_operand_select = 4'h0;
    second_operand_select = 4'h0;
    expected_hits_a = 3'h1;
    expected_hits_b = 3'h0;
    {start_falling, stop_a_falling, stop_a_both} = 3'h0;
    {stop_b_falling, stop_b_both} = 2'h0;
    repeat (20) @(posedge clk);
    #5;
    reset = 1'b0;
    repeat (3) @(posedge clk);
    #5;
    // Both edges on A with falling also set: four hits from two pulses.
    {stop_a_falling, stop_a_both} = 2'h3;
    {expected_hits_a, expected_hits_b} = {3'h4, 3'h0};
    {first_operand_select, second_operand_select} = {4'h4, 4'h1};
    w1 = 2 + ($random(seed) & 7);
    pulse(0, 2, 0);
    pulse(10, 4, 1);
    pulse(30, w1, 1);
    run(mk(0, 0, 20 + w1, 0, 0, 0, -1));
    // Falling start; a B pulse ahead of that edge must be refused.
    {start_falling, stop_b_falling, stop_a_falling, stop_a_both} = 4'hC;
    {expected_hits_a, expected_hits_b} = {3'h1, 3'h2};
    {first_operand_select, second_operand_select} = {4'hA, 4'h1};
    pulse(0, 3, 0);
    pulse(1, 1, 2);
    pulse(10, 3, 2);
    pulse(20, 3, 2);
    pulse(30, 2, 1);
    run(mk(0, 0, 16'hFFF9, 0, 0, 0, -1));
    {start_falling, stop_b_falling} = 2'h0;
    mode_two = 1'b1;
    auto_sum_three_hits = 1'b1;
    {expected_hits_a, expected_hits_b} = {3'h3, 3'h2};
    {first_operand_select, second_operand_select} = {4'h5, 4'h2};
    g1 = 5 + ($random(seed) & 15);
    g2 = 5 + ($random(seed) & 15);
    pulse(0, 2, 0);
    pulse(10, 2, 1);
    pulse(12, 2, 2);
    pulse(10 + g1, 2, 1);
    pulse(10 + g1 + g2, 2, 1);
    run(mk(0, 1, 10, 10 + g1, 10 + g1 + g2, 3, -1));
    auto_sum_three_hits = 1'b0;
    analog_enable = 1'b1;
    {first_operand_select, second_operand_select} = {4'h9, 4'h3};
    for (int c = 0; c < 4; c++) begin
      cap_charge_time = c[1:0];
      pulse(0, 2, 0);
      pulse(8, 2, 1);
      pulse(15, 2, 3);
      pulse(30, 2, 3);
      pulse(50, 2, 3);
      run(mk(0, 0, 50, 0, 0, 3, chg_cyc[c]));
    end
    analog_enable = 1'b0;
    for (int c = 0; c < 3; c++) begin
      timeout_window_select = c[1:0];
      pulse(0, 2, 0);
      pulse(10, 2, 1);
      run(mk(1, 0, tmo_cyc[c] + 8, 0, 0, 8, -1));
    end
    // Mode one with no stops only ends when the counter runs out.
    mode_two = 1'b0;
    pulse(0, 2, 0);
    run(mk(1, 0, 65543, 0, 0, 8, -1));
    finish_test();
  end
endmodule : tdc_hit_measurement_control_tb_top
